// *** tap_pkg.sv ***
package tap_pkg;
  // register lengths
  localparam int IR_W     = 6;
  localparam int ID_W     = 32;
  localparam int STATUS_W = 12;
  localparam int USIG_W   = 16;
  localparam int LADDR_W  = 75;
  localparam int LDATA_W  = 81;
  localparam int CADDR_W  = 4;
  localparam int CDATA_W  = 41;
  localparam int DR_IDX_W = 7;
  // instruction codes
  localparam logic [5:0] CODE_EXTEST          = 6'h00;
  localparam logic [5:0] CODE_LOGIC_ADDR      = 6'h01;
  localparam logic [5:0] CODE_LOGIC_DATA      = 6'h02;
  localparam logic [5:0] CODE_AND_ERASE       = 6'h03;
  localparam logic [5:0] CODE_ARCH_ERASE      = 6'h04;
  localparam logic [5:0] CODE_LOGIC_WRITE     = 6'h05;
  localparam logic [5:0] CODE_FUSE_WRITE      = 6'h06;
  localparam logic [5:0] CODE_BYPASS          = 6'h07;
  localparam logic [5:0] CODE_LOGIC_READ      = 6'h08;
  localparam logic [5:0] CODE_DISCHARGE       = 6'h09;
  localparam logic [5:0] CODE_CFG_ADDR        = 6'h0A;
  localparam logic [5:0] CODE_CFG_DATA        = 6'h0B;
  localparam logic [5:0] CODE_CFG_ERASE       = 6'h0C;
  localparam logic [5:0] CODE_CFG_WRITE       = 6'h0D;
  localparam logic [5:0] CODE_CFG_READ        = 6'h0E;
  localparam logic [5:0] CODE_FULL_ERASE      = 6'h16;
  localparam logic [5:0] CODE_SAFE_HOLD       = 6'h17;
  localparam logic [5:0] CODE_WRITE_MODE_ON   = 6'h18;
  localparam logic [5:0] CODE_IDCODE          = 6'h19;
  localparam logic [5:0] CODE_WRITE_MODE_OFF  = 6'h1A;
  localparam logic [5:0] CODE_STATUS          = 6'h1B;
  localparam logic [5:0] CODE_SAMPLE          = 6'h1C;
  localparam logic [5:0] CODE_USIG_ERASE      = 6'h1D;
  localparam logic [5:0] CODE_USIG_LOAD       = 6'h1E;
  localparam logic [5:0] CODE_USIG_WRITE      = 6'h1F;
  // idle edge count at which erase/program fires (second edge)
  localparam logic [1:0] IDLE_FIRE_CNT = 2'h1;
  localparam logic [31:0] ID_DEFAULT   = 32'h0A5C_3001;  // arbitrary value

  typedef enum logic [15:0] {
    S_RESET   = 16'h0001,
    S_IDLE    = 16'h0002,
    S_SEL_DR  = 16'h0004,
    S_CAP_DR  = 16'h0008,
    S_SH_DR   = 16'h0010,
    S_EX1_DR  = 16'h0020,
    S_PAU_DR  = 16'h0040,
    S_EX2_DR  = 16'h0080,
    S_UPD_DR  = 16'h0100,
    S_SEL_IR  = 16'h0200,
    S_CAP_IR  = 16'h0400,
    S_SH_IR   = 16'h0800,
    S_EX1_IR  = 16'h1000,
    S_PAU_IR  = 16'h2000,
    S_EX2_IR  = 16'h4000,
    S_UPD_IR  = 16'h8000
  } tap_state_t;
endpackage

// *** jtag_tap_config_port.sv ***
`timescale 1ns/1ps
// Summary of operation
// (R1) tdi/tms sampled on rising tck, tdo changes on falling tck.
// (R2) sixteen-state controller stepped by tck, next state from state and tms.
// (R3) five tms-high edges reach test-logic-reset; only it holds with tms high.
// (R4) starts in test-logic-reset; first move out is to run-test/idle.
// (R5) idle with nothing pending does nothing.
// (R6) capture-dr parallel-loads the register chosen by the instruction.
// (R7) capture-ir loads the identification code into the shift stage.
// (R8) capture, shift, exit1, pause, exit2, update paths per the standard graph.
// (R9) erase/program act on the second edge after the next idle entry; others act at update.
// (R10) six-bit instruction register shifted between tdi and tdo.
// (R11) extest, sample/preload and codes with msb set select bypass.
// (R12) bypass code 000111 passes data without disturbing normal operation.
// (R13) logic address 75 bits, logic data 81 bits, logic read loads from memory.
// (R14) config address 4 bits, config data 41 bits.
// (R15) config read loads 41 bits from memory; discharge code fires discharge.
// (R16) bulk erase codes: and, architecture, config, signature, everything.
// (R17) write codes: logic column, security fuse, config column, signature.
// (R18) safe-hold code and all programming codes force safe outputs; the signature load code 011110 does not force them here.
// (R19) write mode on holds outputs safe; write mode off restores them.
// (R20) identification code selects 32-bit id register, device stays functional.
// (R21) id register readable right after reset without instruction scan.
// (R22) status code selects 12-bit status; signature load selects 16 bits.
// (R23) bypass is one stage, one cycle from tdi to tdo.
// (R24) erase/program fire at second idle edge and only in write mode.
// (R25) status capture latches the twelve comparator outputs.
// (R26) test-logic-reset cancels write mode like the write-mode-off code.
// (R27) unassigned codes below 100000 act as bypass.
module jtag_tap_config_port
  import tap_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = tap_pkg::ID_DEFAULT  // arbitrary value
) (
  // system clock domain
  input  wire logic                       clk,
  input  wire logic                       rst,
  // test port
  input  wire logic                       tck,
  input  wire logic                       tms,
  input  wire logic                       tdi,
  output logic                            tdo,
  output logic                            tdo_oe,
  // comparator levels, asynchronous
  input  wire logic [tap_pkg::STATUS_W-1:0] comparator_in,
  // array read data, static while read
  input  wire logic [tap_pkg::LDATA_W-1:0]  nv_logic_rd,
  input  wire logic [tap_pkg::CDATA_W-1:0]  nv_cfg_rd,
  input  wire logic [tap_pkg::USIG_W-1:0]   nv_usig_rd,
  // array write side, tck domain, static after update
  output logic [tap_pkg::LADDR_W-1:0]       logic_addr,
  output logic [tap_pkg::LDATA_W-1:0]       logic_data,
  output logic [tap_pkg::CADDR_W-1:0]       cfg_addr,
  output logic [tap_pkg::CDATA_W-1:0]       cfg_data,
  output logic [tap_pkg::USIG_W-1:0]        user_signature,
  // clk domain requests
  output logic                            outputs_safe_hold,
  output logic                            nv_write_mode,
  output logic                            nv_action_pulse,
  output logic [tap_pkg::IR_W-1:0]        nv_action_code
);
  import tap_pkg::*;

  tap_state_t            state;
  tap_state_t            next_state;
  logic                  rst_meta;
  logic                  tap_rst;
  logic [STATUS_W-1:0]   cmp_meta;
  logic [STATUS_W-1:0]   cmp_sync;
  logic [IR_W-1:0]       ir;
  logic [IR_W-1:0]       ir_shift;
  logic [LDATA_W-1:0]    dr;
  logic [LDATA_W-1:0]    next_dr;
  logic                  write_mode;
  logic                  pending;
  logic [1:0]            idle_cnt;
  logic                  act_toggle;
  logic [IR_W-1:0]       act_code;
  logic                  safe_meta;
  logic                  write_meta;
  logic [2:0]            act_sync;

  // power-on reset carried into the tck domain; tms-high covers later resets
  always_ff @(posedge tck) begin
    rst_meta <= rst;
    tap_rst  <= rst_meta;
  end

  // comparators are analog, so synchronise before capture
  always_ff @(posedge tck) begin
    cmp_meta <= comparator_in;
    cmp_sync <= cmp_meta;
  end

  always_comb begin
    unique case (state)  // [R2] [R8]
      S_RESET:  next_state = tms ? S_RESET  : S_IDLE;  // [R3] [R4]
      S_IDLE:   next_state = tms ? S_SEL_DR : S_IDLE;
      S_SEL_DR: next_state = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR:  next_state = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: next_state = tms ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: next_state = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = tms ? S_SEL_DR : S_IDLE;
      S_SEL_IR: next_state = tms ? S_RESET  : S_CAP_IR;
      S_CAP_IR: next_state = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR:  next_state = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: next_state = tms ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: next_state = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = tms ? S_SEL_DR : S_IDLE;
      default:  next_state = S_RESET;
    endcase
  end

  always_ff @(posedge tck) begin  // [R1]
    if (tap_rst) begin
      state <= S_RESET;  // [R4]
    end else begin
      state <= next_state;
    end
  end

  // data register selection
  wire sel_laddr  = (ir == CODE_LOGIC_ADDR);  // [R13]
  wire sel_ldata  = (ir == CODE_LOGIC_DATA) | (ir == CODE_LOGIC_READ);
  wire sel_caddr  = (ir == CODE_CFG_ADDR);  // [R14]
  wire sel_cdata  = (ir == CODE_CFG_DATA) | (ir == CODE_CFG_READ);  // [R15]
  wire sel_id     = (ir == CODE_IDCODE);  // [R20]
  wire sel_status = (ir == CODE_STATUS);  // [R22]
  wire sel_usig   = (ir == CODE_USIG_LOAD) | (ir == CODE_USIG_WRITE);
  // everything else, msb-set codes and unassigned ones included
  wire sel_bypass = !(sel_laddr | sel_ldata | sel_caddr | sel_cdata
                      | sel_id | sel_status | sel_usig);  // [R11] [R12] [R27]

  wire is_nv_op = (ir == CODE_AND_ERASE) | (ir == CODE_ARCH_ERASE)
                | (ir == CODE_LOGIC_WRITE) | (ir == CODE_FUSE_WRITE)
                | (ir == CODE_CFG_ERASE) | (ir == CODE_CFG_WRITE)
                | (ir == CODE_FULL_ERASE) | (ir == CODE_USIG_ERASE)
                | (ir == CODE_USIG_WRITE);  // [R16] [R17]
  wire code_nv_op = (ir_shift == CODE_AND_ERASE)
                  | (ir_shift == CODE_ARCH_ERASE)
                  | (ir_shift == CODE_LOGIC_WRITE)
                  | (ir_shift == CODE_FUSE_WRITE)
                  | (ir_shift == CODE_CFG_ERASE)
                  | (ir_shift == CODE_CFG_WRITE)
                  | (ir_shift == CODE_FULL_ERASE)
                  | (ir_shift == CODE_USIG_ERASE)
                  | (ir_shift == CODE_USIG_WRITE);
  wire forces_safe = is_nv_op | sel_laddr | sel_ldata | sel_caddr
                   | sel_cdata | (ir == CODE_DISCHARGE)
                   | (ir == CODE_SAFE_HOLD)
                   | (ir == CODE_WRITE_MODE_ON);  // [R18]
  wire safe_tck = forces_safe | write_mode;  // [R19]

  wire [DR_IDX_W-1:0] dr_msb =
      sel_laddr  ? DR_IDX_W'(LADDR_W - 1)  :
      sel_ldata  ? DR_IDX_W'(LDATA_W - 1)  :
      sel_caddr  ? DR_IDX_W'(CADDR_W - 1)  :
      sel_cdata  ? DR_IDX_W'(CDATA_W - 1)  :
      sel_id     ? DR_IDX_W'(ID_W - 1)     :
      sel_status ? DR_IDX_W'(STATUS_W - 1) :
      sel_usig   ? DR_IDX_W'(USIG_W - 1)   : DR_IDX_W'(0);  // [R23]

  // read codes pull fresh array data, plain select codes read back holding
  wire [LDATA_W-1:0] capture_val =
      sel_laddr  ? LDATA_W'(logic_addr) :
      (ir == CODE_LOGIC_READ) ? nv_logic_rd :
      sel_ldata  ? logic_data :
      sel_caddr  ? LDATA_W'(cfg_addr) :
      (ir == CODE_CFG_READ) ? LDATA_W'(nv_cfg_rd) :
      sel_cdata  ? LDATA_W'(cfg_data) :
      sel_id     ? LDATA_W'(ID_VALUE) :
      sel_status ? LDATA_W'(cmp_sync) :
      (ir == CODE_USIG_LOAD) ? LDATA_W'(nv_usig_rd) :
      sel_usig   ? LDATA_W'(user_signature) : LDATA_W'(0);

  // shorter registers shift in at their own top bit
  always_comb begin
    next_dr = dr >> 1;
    next_dr[dr_msb] = tdi;
  end

  always_ff @(posedge tck) begin
    if (state == S_CAP_DR) begin
      dr <= capture_val;  // [R6] [R25]
    end else if (state == S_SH_DR) begin
      dr <= next_dr;  // [R23]
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      ir_shift <= CODE_IDCODE;
    end else if (state == S_CAP_IR) begin
      ir_shift <= CODE_IDCODE;  // [R7]
    end else if (state == S_SH_IR) begin
      ir_shift <= {tdi, ir_shift[IR_W-1:1]};  // [R10]
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst || state == S_RESET) begin
      ir <= CODE_IDCODE;  // [R21]
    end else if (state == S_UPD_IR) begin
      ir <= ir_shift;  // [R9]
    end
  end

  // holding registers take shifted data at update
  always_ff @(posedge tck) begin
    if (tap_rst) begin
      logic_addr     <= '0;
      logic_data     <= '0;
      cfg_addr       <= '0;
      cfg_data       <= '0;
      user_signature <= '0;
    end else if (state == S_UPD_DR) begin
      if (sel_laddr) logic_addr <= dr[LADDR_W-1:0];  // [R13]
      if (sel_ldata) logic_data <= dr;
      if (sel_caddr) cfg_addr <= dr[CADDR_W-1:0];  // [R14]
      if (sel_cdata) cfg_data <= dr[CDATA_W-1:0];
      if (sel_usig) user_signature <= dr[USIG_W-1:0];  // [R22]
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst || state == S_RESET) begin
      write_mode <= 1'b0;  // [R26]
    end else if (state == S_UPD_IR) begin
      if (ir_shift == CODE_WRITE_MODE_ON) write_mode <= 1'b1;  // [R19]
      if (ir_shift == CODE_WRITE_MODE_OFF) write_mode <= 1'b0;
    end
  end

  // erase/program wait for idle; counter saturates so it fires once
  wire idle_fire = (state == S_IDLE) && (idle_cnt == IDLE_FIRE_CNT)
                   && pending && write_mode;  // [R24]
  wire disch_fire = (state == S_UPD_IR) && (ir_shift == CODE_DISCHARGE);

  always_ff @(posedge tck) begin
    if (tap_rst || state != S_IDLE) begin
      idle_cnt <= 2'h0;
    end else if (idle_cnt != 2'h3) begin
      idle_cnt <= idle_cnt + 2'h1;
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst || state == S_RESET) begin
      pending <= 1'b0;
    end else if (state == S_UPD_IR) begin
      pending <= code_nv_op;  // [R9]
    end else if (idle_fire) begin
      pending <= 1'b0;  // [R5]
    end
  end

  always_ff @(posedge tck) begin
    if (tap_rst) begin
      act_toggle <= 1'b0;
      act_code   <= CODE_BYPASS;
    end else if (idle_fire || disch_fire) begin
      act_toggle <= ~act_toggle;  // [R15] [R24]
      act_code   <= idle_fire ? ir : CODE_DISCHARGE;
    end
  end

  // tdo moves on the falling edge so the far end samples it mid-bit
  always_ff @(negedge tck) begin
    if (tap_rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= (state == S_SH_IR) ? ir_shift[0] : dr[0];  // [R1]
      tdo_oe <= (state == S_SH_IR) || (state == S_SH_DR);
    end
  end

  // code is stable long before the toggle lands, so sampling it is safe
  always_ff @(posedge clk) begin
    if (rst) begin
      safe_meta         <= 1'b0;
      outputs_safe_hold <= 1'b0;
      write_meta        <= 1'b0;
      nv_write_mode     <= 1'b0;
      act_sync          <= 3'h0;
      nv_action_pulse   <= 1'b0;
      nv_action_code    <= CODE_BYPASS;
    end else begin
      safe_meta         <= safe_tck;
      outputs_safe_hold <= safe_meta;  // [R18]
      write_meta        <= write_mode;
      nv_write_mode     <= write_meta;
      act_sync          <= {act_sync[1:0], act_toggle};
      nv_action_pulse   <= act_sync[2] ^ act_sync[1];
      if (act_sync[2] ^ act_sync[1]) nv_action_code <= act_code;
    end
  end

  sequence s_idle_entry;
    (state != S_IDLE) ##1 (state == S_IDLE) && pending && write_mode;
  endsequence

  property p_tms_reset;
    @(posedge tck) disable iff (tap_rst)
      tms [*5] |=> (state == S_RESET);
  endproperty
  a_tms_reset: assert property (p_tms_reset)  // [R3]
    else $error("five tms-high edges did not reach reset");

  property p_reset_exit;
    @(posedge tck) disable iff (tap_rst)
      (state == S_RESET) && !tms |=> (state == S_IDLE);
  endproperty
  a_reset_exit: assert property (p_reset_exit)  // [R4]
    else $error("reset state did not move to idle");

  property p_capture_ir;
    @(posedge tck) disable iff (tap_rst)
      (state == S_CAP_IR) ##1 (state == S_SH_IR) |-> ir_shift[0];
  endproperty
  a_capture_ir: assert property (p_capture_ir)  // [R7]
    else $error("capture-ir did not load the id code");

  property p_ir_update;
    @(posedge tck) disable iff (tap_rst)
      (state == S_UPD_IR) |=> (ir == $past(ir_shift));
  endproperty
  a_ir_update: assert property (p_ir_update)  // [R9]
    else $error("instruction not taken at update");

  property p_bypass_stage;
    @(posedge tck) disable iff (tap_rst)
      (state == S_SH_DR) && sel_bypass |=> (dr[0] == $past(tdi));
  endproperty
  a_bypass_stage: assert property (p_bypass_stage)  // [R23]
    else $error("bypass stage not one cycle");

  property p_fire_second_edge;
    @(posedge tck) disable iff (tap_rst)
      s_idle_entry ##1 (state == S_IDLE) |-> idle_fire;
  endproperty
  a_fire_second_edge: assert property (p_fire_second_edge)  // [R24]
    else $error("pending action missed second idle edge");

  property p_no_early_fire;
    @(posedge tck) disable iff (tap_rst)
      (state != S_IDLE) ##1 (state == S_IDLE) |-> !idle_fire;
  endproperty
  a_no_early_fire: assert property (p_no_early_fire)  // [R24]
    else $error("action fired on first idle edge");

  property p_idle_quiet;
    @(posedge tck) disable iff (tap_rst)
      (state == S_IDLE) && !pending |-> !idle_fire;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)  // [R5]
    else $error("idle acted with nothing pending");

  property p_reset_cancels;
    @(posedge tck) disable iff (tap_rst)
      (state == S_RESET) |=> !write_mode && !pending;
  endproperty
  a_reset_cancels: assert property (p_reset_cancels)  // [R26]
    else $error("reset state left write mode on");

  property p_status_capture;
    @(posedge tck) disable iff (tap_rst)
      (state == S_CAP_DR) && sel_status
        |=> (dr[STATUS_W-1:0] == $past(cmp_sync));
  endproperty
  a_status_capture: assert property (p_status_capture)  // [R25]
    else $error("status capture missed comparators");

  property p_safe_hold;
    @(posedge tck) disable iff (tap_rst)
      (ir == CODE_SAFE_HOLD) || write_mode |-> safe_tck;
  endproperty
  a_safe_hold: assert property (p_safe_hold)  // [R18]
    else $error("safe hold not requested");
endmodule

// *** tap_host.sv ***
`timescale 1ns/1ps
module tap_host (
  // test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // tck stands low outside frames; unused tdi toggles so stale bits show
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #6;
    o   = tdo;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask
  task automatic idle(input int n);
    logic o;
    repeat (n) step(1'b0, ~tdi, o);
  endtask
  task automatic reset5();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
  endtask
  task automatic enter_shift(input logic ir);
    logic o;
    step(1'b1, ~tdi, o);
    if (ir) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  // lsb first; last bit leaves with tms high, ends on idle entry
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic o;
    dout = '0;
    enter_shift(ir);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule

// *** jtag_tap_config_port_bench.sv ***
`timescale 1ns/1ps
module jtag_tap_config_port_bench;
  import tap_pkg::*;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                tck;
  logic                tms;
  logic                tdi;
  logic                tdo;
  logic [STATUS_W-1:0] comparator_in = '0;
  logic [LDATA_W-1:0]  nv_logic_rd = '0;
  logic [CDATA_W-1:0]  nv_cfg_rd = '0;
  logic [USIG_W-1:0]   nv_usig_rd = '0;
  logic [LADDR_W-1:0]  logic_addr;
  logic [CADDR_W-1:0]  cfg_addr;
  logic [LDATA_W-1:0]  logic_data;
  logic [CDATA_W-1:0]  cfg_data;
  logic [USIG_W-1:0]   usig;
  logic                tdo_oe;
  int                  oe_edges = 0;
  logic                safe;
  logic                wmode;
  logic                pulse;
  logic [IR_W-1:0]     code;
  logic [IR_W-1:0]     last_code = '0;
  logic [15:0]         lfsr = 16'hD7E5;
  logic [127:0]        d1;
  logic [127:0]        d2;
  logic [127:0]        q;
  logic [127:0]        e;
  int                  err_count = 0;
  int                  cmp_count = 0;
  int                  pulses = 0;
  int                  exp_pulses = 0;
  logic [5:0]          byp [9] = '{6'h00, 6'h07, 6'h1C, 6'h20, 6'h3F,
                                   6'h0F, 6'h10, 6'h15, 6'h2A};
  logic [5:0]          rdc [5] = '{CODE_IDCODE, CODE_STATUS, CODE_CFG_READ,
                                   CODE_USIG_LOAD, CODE_LOGIC_READ};
  int                  rdw [5] = '{ID_W, STATUS_W, CDATA_W, USIG_W, LDATA_W};
  logic [5:0]          hc [4] = '{CODE_CFG_ADDR, CODE_LOGIC_ADDR,
                                  CODE_CFG_DATA, CODE_LOGIC_DATA};
  int                  hw [4] = '{CADDR_W, LADDR_W, CDATA_W, LDATA_W};
  logic [5:0]          act [9] = '{6'h03, 6'h04, 6'h0C, 6'h1D, 6'h16,
                                   6'h05, 6'h06, 6'h0D, 6'h1F};

  always #12.5 clk = ~clk;

  tap_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jtag_tap_config_port dut (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .comparator_in(comparator_in), .nv_logic_rd(nv_logic_rd),
    .nv_cfg_rd(nv_cfg_rd), .nv_usig_rd(nv_usig_rd),
    .logic_addr(logic_addr), .logic_data(logic_data), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .user_signature(usig), .outputs_safe_hold(safe),
    .nv_write_mode(wmode), .nv_action_pulse(pulse),
    .nv_action_code(code));

  // sampled away from the launching edge
  always @(negedge clk) begin
    if (pulse === 1'b1) begin
      pulses++;
      last_code = code;
    end
  end

  // counts shift edges that see the output driven
  always @(posedge tck) begin
    if (tdo_oe === 1'b1) oe_edges++;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [127:0] rnd128();
    logic [127:0] r;
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      r[i*16 +: 16] = lfsr;
    end
    return r;
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic load_ir(input logic [5:0] c);
    host.scan(1'b1, IR_W, {122'h0, c}, q);
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask

  initial begin
    #500000;
    err_count++;
    $display("[FAIL] %0t run hung", $time);
    end_sim();
  end

  initial begin
    fork
      host.reset5();
      repeat (5) @(posedge clk);
    join
    rst <= 1'b0;
    host.reset5();
    host.idle(1);
    oe_edges = 0;
    host.scan(1'b0, ID_W, '0, q);
    check(q[31:0], ID_DEFAULT);
    check(oe_edges, ID_W);
    check(tdo_oe, 1'b0);
    host.scan(1'b1, IR_W, 128'h07, q);
    check(q[5:0], CODE_IDCODE);
    $display("test identification done");
    foreach (byp[i]) begin
      load_ir(byp[i]);
      d1 = rnd128();
      host.scan(1'b0, 8, d1, q);
      check(q[7:0], {d1[6:0], 1'b0});
      check(safe, 1'b0);
    end
    $display("test bypass done");
    d1 = rnd128();
    @(posedge clk);
    comparator_in <= d1[11:0];
    nv_cfg_rd     <= d1[52:12];
    nv_usig_rd    <= d1[68:53];
    nv_logic_rd   <= d1[127:47];
    host.idle(3);
    foreach (rdc[i]) begin
      load_ir(rdc[i]);
      d2 = rnd128();
      host.scan(1'b0, rdw[i] + 2, d2, q);
      case (i)
        0: e = 128'(ID_DEFAULT);
        1: e = 128'(comparator_in);
        2: e = 128'(nv_cfg_rd);
        3: e = 128'(nv_usig_rd);
        default: e = 128'(nv_logic_rd);
      endcase
      check(q, e | (128'(d2[1:0]) << rdw[i]));
      if (i == 3) check(usig, d2[17:2]);
    end
    $display("test capture done");
    foreach (hc[i]) begin
      load_ir(hc[i]);
      d1 = rnd128();
      host.scan(1'b0, hw[i], d1, q);
      d2 = rnd128();
      host.scan(1'b0, hw[i] + 2, d2, q);
      e = (d1 & ((128'h1 << hw[i]) - 1)) | (128'(d2[1:0]) << hw[i]);
      check(q, e);
      if (i == 0) check(cfg_addr, d2[5:2]);
      if (i == 1) check(logic_addr, d2[76:2]);
      if (i == 2) check(cfg_data, d2[42:2]);
      if (i == 3) check(logic_data, d2[82:2]);
    end
    $display("test holding registers done");
    load_ir(CODE_AND_ERASE);
    host.idle(2);
    settle();
    check(pulses, exp_pulses);
    load_ir(CODE_WRITE_MODE_ON);
    settle();
    check(wmode, 1'b1);
    check(safe, 1'b1);
    foreach (act[i]) begin
      load_ir(act[i]);
      settle();
      check(pulses, exp_pulses);
      host.idle(2);
      exp_pulses++;
      settle();
      check(pulses, exp_pulses);
      check(last_code, act[i]);
      check(safe, 1'b1);
    end
    load_ir(CODE_DISCHARGE);
    exp_pulses++;
    settle();
    check(pulses, exp_pulses);
    check(last_code, CODE_DISCHARGE);
    $display("test actions done");
    load_ir(CODE_WRITE_MODE_OFF);
    settle();
    check(wmode, 1'b0);
    check(safe, 1'b0);
    load_ir(CODE_SAFE_HOLD);
    settle();
    check(safe, 1'b1);
    check(wmode, 1'b0);
    load_ir(CODE_WRITE_MODE_ON);
    host.enter_shift(1'b0);
    host.reset5();
    // cancel lands on the first edge spent in reset; tms high holds it
    host.reset5();
    settle();
    check(wmode, 1'b0);
    check(safe, 1'b0);
    host.idle(1);
    host.scan(1'b0, ID_W, '0, q);
    check(q[31:0], ID_DEFAULT);
    check(pulses, exp_pulses);
    $display("test modes done");
    end_sim();
  end
endmodule
